// ===== rtl/sbrc_reset_clock_ctrl.sv
/*
  Software reset holds and clock stops for the internal digital sub-blocks.
  Holds two 16-bit registers reached by the internal register port
  (index, write strobe, read strobe) on mclk. Assumes srst is power-on
  reset only and that the serial port logic drives the register port.
*/
`timescale 1ns/1ps
module sbrc_reset_clock_ctrl
  import sbrc_pkg::*;
(
  // Clock and power-on reset
  input  wire logic            mclk,
  input  wire logic            srst,
  // Internal register port
  input  wire logic            regIndex,
  input  wire logic            regWrite,
  input  wire logic            regRead,
  input  wire sbrc_pkg::sbrc_word_t regWdata,
  output sbrc_pkg::sbrc_word_t regRdata,
  output logic                 regRvalid,
  // Sub-block reset holds
  output logic                 biasTrimResetHold,
  output logic                 fuseMemoryResetHold,
  output sbrc_pkg::sbrc_mon_t  monitorResetHold,
  // Sub-block clock stops (level, registered)
  output sbrc_pkg::sbrc_mon_t  monitorClockStop,
  output logic                 coreLogicClockStop,
  // Gated clocks for the monitors and the core logic
  output logic                 activityMonAClk,
  output logic                 activityMonBClk,
  output logic                 signalLossMonAClk,
  output logic                 signalLossMonBClk,
  output logic                 signalLossMonCClk,
  output logic                 coreLogicClk
);
  import sbrc_pkg::*;

  sbrc_word_t resetHold_reg;
  sbrc_word_t resetHold_next;
  sbrc_word_t clockStop_reg;
  sbrc_word_t clockStop_next;
  sbrc_word_t rdata_reg;
  sbrc_word_t rdata_next;
  logic       rvalid_reg;
  sbrc_port_e port_reg;
  sbrc_port_e port_next;
  sbrc_mon_t  monStop;

  // Read value of a register: only writable bits are visible
  function automatic sbrc_word_t readMask(input logic idx,
                                          input sbrc_word_t rh,
                                          input sbrc_word_t cs);
    readMask = (idx == `SBRC_IDX_RESET_HOLD) ? (rh & `SBRC_RH_WMASK)
                                             : (cs & `SBRC_CS_WMASK);
  endfunction : readMask

  // Access decode, refused once the core clock has been stopped
  wire portOpen  = (port_reg == SBRC_OPEN);
  wire wrHold    = portOpen && regWrite && (regIndex == `SBRC_IDX_RESET_HOLD);
  wire wrStop    = portOpen && regWrite && (regIndex == `SBRC_IDX_CLOCK_STOP);
  wire rdAccept  = portOpen && regRead;

  // Writes store only writable bits; reserved writable bits simply store
  assign resetHold_next = wrHold ? (regWdata & `SBRC_RH_WMASK)
                                 : resetHold_reg;
  // Core stop bit is sticky: a write cannot clear it
  assign clockStop_next = wrStop
    ? ((regWdata & `SBRC_CS_WMASK)
       | (clockStop_reg & (16'h0001 << `SBRC_CS_CORE)))
    : clockStop_reg;
  assign rdata_next = rdAccept ? readMask(regIndex, resetHold_reg,
                                          clockStop_reg)
                               : rdata_reg;
  assign port_next = clockStop_next[`SBRC_CS_CORE] ? SBRC_LOCKED
                                                   : port_reg;

  // Register state; only power-on reset clears it
  always_ff @(posedge mclk) begin
    if (srst) begin
      resetHold_reg <= `SBRC_RH_RESET;
      clockStop_reg <= `SBRC_CS_RESET;
      rdata_reg     <= 16'h0000;
      rvalid_reg    <= 1'b0;
      port_reg      <= SBRC_OPEN;
    end else begin
      resetHold_reg <= resetHold_next;
      clockStop_reg <= clockStop_next;
      rdata_reg     <= rdata_next;
      rvalid_reg    <= rdAccept;
      port_reg      <= port_next;
    end
  end

  // Hold and stop levels registered from the next-state register values
  always_ff @(posedge mclk) begin
    if (srst) begin
      biasTrimResetHold   <= 1'b0;
      fuseMemoryResetHold <= 1'b0;
      monitorResetHold    <= 5'h00;
      monitorClockStop    <= 5'h00;
      coreLogicClockStop  <= 1'b0;
    end else begin
      biasTrimResetHold   <= resetHold_next[`SBRC_RH_BIAS];
      fuseMemoryResetHold <= resetHold_next[`SBRC_RH_FUSE];
      monitorResetHold    <= { resetHold_next[`SBRC_RH_ACT_B],
                               resetHold_next[`SBRC_RH_ACT_A],
                               resetHold_next[`SBRC_RH_LOSS_C],
                               resetHold_next[`SBRC_RH_LOSS_B],
                               resetHold_next[`SBRC_RH_LOSS_A] };
      monitorClockStop    <= monStop;
      coreLogicClockStop  <= clockStop_next[`SBRC_CS_CORE];
    end
  end

  // Monitor stop order: {act B, act A, loss C, loss B, loss A}
  assign monStop = { clockStop_next[`SBRC_CS_ACT_B],
                     clockStop_next[`SBRC_CS_ACT_A],
                     clockStop_next[`SBRC_CS_LOSS_C],
                     clockStop_next[`SBRC_CS_LOSS_B],
                     clockStop_next[`SBRC_CS_LOSS_A] };

  assign regRdata  = rdata_reg;
  assign regRvalid = rvalid_reg;

  // Gated clocks: the register port itself sits on coreLogicClk in the
  // chip, which is why a stopped core can never be reopened by software
  sbrc_clock_stop_cell uActB (
    .ref_input_true(mclk), .clkOut(activityMonBClk),
    .stopReq(monitorClockStop[4]));
  sbrc_clock_stop_cell uActA (
    .ref_input_true(mclk), .clkOut(activityMonAClk),
    .stopReq(monitorClockStop[3]));
  sbrc_clock_stop_cell uLossC (
    .ref_input_true(mclk), .clkOut(signalLossMonCClk),
    .stopReq(monitorClockStop[2]));
  sbrc_clock_stop_cell uLossB (
    .ref_input_true(mclk), .clkOut(signalLossMonBClk),
    .stopReq(monitorClockStop[1]));
  sbrc_clock_stop_cell uLossA (
    .ref_input_true(mclk), .clkOut(signalLossMonAClk),
    .stopReq(monitorClockStop[0]));
  sbrc_clock_stop_cell uCore (
    .ref_input_true(mclk), .clkOut(coreLogicClk),
    .stopReq(coreLogicClockStop));
endmodule : sbrc_reset_clock_ctrl

// ===== rtl/sbrc_consts.svh
/*
  Constants for the sub-block reset hold and clock stop registers:
  register indices, field positions and reset values.
  Assumes inclusion from the package and the design modules only.
*/
`ifndef SBRC_CONSTS_SVH
`define SBRC_CONSTS_SVH

// Register indices on the internal register port (chosen locally)
`define SBRC_IDX_RESET_HOLD   1'h0
`define SBRC_IDX_CLOCK_STOP   1'h1

// Reset hold register fields
`define SBRC_RH_FUSE          0
`define SBRC_RH_LOSS_A        1
`define SBRC_RH_LOSS_B        2
`define SBRC_RH_LOSS_C        3
`define SBRC_RH_ACT_A         4
`define SBRC_RH_ACT_B         5
`define SBRC_RH_BIAS          8
`define SBRC_RH_SPARE         11

// Clock stop register fields
`define SBRC_CS_SPARE0        0
`define SBRC_CS_LOSS_A        1
`define SBRC_CS_LOSS_B        2
`define SBRC_CS_LOSS_C        3
`define SBRC_CS_ACT_A         4
`define SBRC_CS_ACT_B         5
`define SBRC_CS_SPARE6        6
`define SBRC_CS_SPARE8        8
`define SBRC_CS_CORE          11

// Writable bit masks and reset values
`define SBRC_RH_WMASK         16'h093F
`define SBRC_CS_WMASK         16'h097F
`define SBRC_RH_RESET         16'h0000
`define SBRC_CS_RESET         16'h0000

`endif

// ===== rtl/sbrc_pkg.sv
/*
  Types shared by the sub-block reset and clock stop logic.
  Assumes the constants header is available on the include path.
*/
package sbrc_pkg;
  `include "sbrc_consts.svh"

  typedef logic [15:0] sbrc_word_t;
  typedef logic [4:0]  sbrc_mon_t;

  // Port access state: open until the core clock is stopped
  typedef enum logic {
    SBRC_OPEN,
    SBRC_LOCKED
  } sbrc_port_e;
endpackage : sbrc_pkg

// ===== rtl/sbrc_clock_stop_cell.sv
/*
  Glitch-free clock stop cell for one sub-block clock.
  Assumes ref_input_true is the functional clock of the sub-block and stopReq is
  a level from the mclk register domain, stable around clock edges.
*/
`timescale 1ns/1ps
module sbrc_clock_stop_cell (
  // Clock in and out
  input  wire logic ref_input_true,
  output logic      clkOut,
  // Control
  input  wire logic stopReq
);
  logic enableLatch;

  // Latch opens while clock is low so the enable cannot chop a high phase
  always_latch begin
    if (!ref_input_true) begin
      enableLatch = !stopReq;
    end
  end

  assign clkOut = ref_input_true & enableLatch;
endmodule : sbrc_clock_stop_cell

// ===== testbench/sbrc_reset_clock_ctrl_properties.sv
/*
  Port assertions for the reset hold and clock stop block.
  Assumes binding to sbrc_reset_clock_ctrl, one mclk domain.
*/
`timescale 1ns/1ps
module sbrc_reset_clock_ctrl_properties
  import sbrc_pkg::*;
(
  // Clock, reset and register port
  input wire logic                 mclk,
  input wire logic                 srst,
  input wire logic                 regIndex,
  input wire logic                 regWrite,
  input wire logic                 regRead,
  input wire sbrc_pkg::sbrc_word_t regWdata,
  input wire sbrc_pkg::sbrc_word_t regRdata,
  input wire logic                 regRvalid,
  // Holds, stops and gated clocks
  input wire logic                 biasTrimResetHold,
  input wire logic                 fuseMemoryResetHold,
  input wire sbrc_pkg::sbrc_mon_t  monitorResetHold,
  input wire sbrc_pkg::sbrc_mon_t  monitorClockStop,
  input wire logic                 coreLogicClockStop,
  input wire logic                 activityMonAClk,
  input wire logic                 activityMonBClk,
  input wire logic                 signalLossMonAClk,
  input wire logic                 signalLossMonBClk,
  input wire logic                 signalLossMonCClk,
  input wire logic                 coreLogicClk
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Monitor clocks in the order of the stop bits
  wire sbrc_mon_t monClks = {activityMonBClk, activityMonAClk,
    signalLossMonCClk, signalLossMonBClk, signalLossMonAClk};

  a_hold_write: assert property (regWrite && !regIndex &&
    !coreLogicClockStop |=> {biasTrimResetHold, monitorResetHold,
    fuseMemoryResetHold} == {$past(regWdata[8]), $past(regWdata[5:0])})
    else $error("hold levels differ from written word");
  a_stop_write: assert property (regWrite && regIndex &&
    !coreLogicClockStop |=> monitorClockStop == $past(regWdata[5:1]))
    else $error("stop levels differ from written word");
  a_core_sticky: assert property (coreLogicClockStop |=>
    coreLogicClockStop) else $error("core stop cleared");
  a_lock_refuse: assert property (coreLogicClockStop |=> !regRvalid)
    else $error("read answered while locked");
  a_read_answer: assert property (regRead && !coreLogicClockStop |=>
    regRvalid) else $error("read not answered");
  a_reserved_zero: assert property (regRvalid |-> (regRdata &
    ~($past(regIndex) ? 16'h097F : 16'h093F)) == 16'h0000)
    else $error("read-only bit read nonzero");
  a_mon_gate: assert property (@(negedge mclk) disable iff (srst)
    ((monClks ^ ~monitorClockStop) &
    ~(monitorClockStop ^ $past(monitorClockStop))) == 5'h00)
    else $error("monitor clock state wrong");
  a_core_gate: assert property (@(negedge mclk) disable iff (srst)
    coreLogicClockStop == $past(coreLogicClockStop) |->
    coreLogicClk == !coreLogicClockStop) else $error("core clock wrong");
  a_reset_clear: assert property ($fell(srst) |->
    {regRvalid, biasTrimResetHold, fuseMemoryResetHold, monitorResetHold,
    monitorClockStop, coreLogicClockStop} == 14'h0000)
    else $error("outputs not cleared by reset");
endmodule : sbrc_reset_clock_ctrl_properties

bind sbrc_reset_clock_ctrl sbrc_reset_clock_ctrl_properties u_props (.*);

// ===== testbench/sbrc_reset_clock_ctrl_tb.sv
/*
  Self-checking bench for the reset hold and clock stop block.
  Assumes the design package and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module sbrc_reset_clock_ctrl_tb;
  import sbrc_pkg::*;
  logic       mclk, srst, regIndex, regWrite, regRead, regRvalid;
  logic       biasTrimResetHold, fuseMemoryResetHold, coreLogicClockStop;
  logic       activityMonAClk, activityMonBClk, signalLossMonAClk;
  logic       signalLossMonBClk, signalLossMonCClk, coreLogicClk;
  sbrc_word_t regWdata, regRdata, e;
  sbrc_mon_t  monitorResetHold, monitorClockStop;
  int         miscompares = 0;
  int         checks_done = 0;

  sbrc_reset_clock_ctrl u_dut (.*);

  // 25 ns clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Inputs move 2 ns after the rising edge, clear of sampling
  task automatic step();
    @(posedge mclk);
    #2;
  endtask : step
  task automatic chk(input string nm, input sbrc_word_t seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Extra step at the end keeps strobes from being reassigned at once
  task automatic wr(input logic idx, input sbrc_word_t d);
    regIndex = idx;
    regWdata = d;
    regWrite = 1'b1;
    step();
    regWrite = 1'b0;
    step();
  endtask : wr
  task automatic rd(input logic idx, input sbrc_word_t x, input logic v);
    regIndex = idx;
    regRead = 1'b1;
    step();
    regRead = 1'b0;
    chk("rvalid", 16'(regRvalid), 16'(v));
    if (v) chk("rdata", regRdata, x);
    step();
  endtask : rd
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    {srst, regIndex, regWrite, regRead, regWdata} = {1'b1, 19'h0};
    repeat (16) step();
    srst = 1'b0;
    rd(1'b0, 16'h0000, 1'b1);
    rd(1'b1, 16'h0000, 1'b1);
    for (int i = 0; i < 16; i++) begin
      e = 16'h0001 << i;
      wr(1'b0, e);
      rd(1'b0, e & 16'h093F, 1'b1);
      chk("holds", {7'h00, biasTrimResetHold, 2'h0, monitorResetHold,
        fuseMemoryResetHold}, e & 16'h013F);
    end
    for (int i = 0; i < 11; i++) begin
      e = 16'h0001 << i;
      wr(1'b1, e);
      rd(1'b1, e & 16'h097F, 1'b1);
      chk("stops", {10'h000, monitorClockStop, 1'b0}, e & 16'h003E);
      chk("clks", {9'h000, coreLogicClk, activityMonBClk, activityMonAClk,
        signalLossMonCClk, signalLossMonBClk, signalLossMonAClk, 1'b0},
        16'h0040 | (~e & 16'h003E));
    end
    wr(1'b1, 16'h0800);
    chk("core", {coreLogicClockStop, coreLogicClk}, 16'h0002);
    wr(1'b1, 16'h0000);
    chk("sticky", 16'(coreLogicClockStop), 16'h0001);
    wr(1'b0, 16'h0001);
    chk("locked", 16'(fuseMemoryResetHold), 16'h0000);
    rd(1'b1, 16'h0000, 1'b0);
    srst = 1'b1;
    step();
    srst = 1'b0;
    chk("cleared", 16'(coreLogicClockStop), 16'h0000);
    rd(1'b1, 16'h0000, 1'b1);
    stop_test();
  end
endmodule : sbrc_reset_clock_ctrl_tb
